//--- src/tfl_pkg.sv
// constants, types and field layout for the tx frame length and target state register bank
// What this block does
// - target state is a 4-bit code; idle, ready, active and starred states, two reserved
// - target state display bits 7 to 4 read zero; code sits in bits 3 to 0
// - full-byte count is 13 bits, max 8191: high 8 bits, then bits 7..3
// - bits 2..0 of second length register give trailing bits; zero sends whole bytes
// - trailing partial byte goes out least significant bit first
// - ISO-A anticollision frames may end in a split partial byte
// - no parity bits are generated when ISO-A partial-bit transmission is used
// - anticollision set, idle card, trailing bits nonzero: REQA or WUPA raises parity interrupt
package tfl_pkg;

  // register addresses
  localparam logic [7:0] ADDR_TGT_STATE = 8'h21;
  localparam logic [7:0] ADDR_CNT_HIGH  = 8'h22;
  localparam logic [7:0] ADDR_CNT_LOW   = 8'h23;
  localparam logic [7:0] ADDR_IRQ_STS   = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h31;
  localparam logic [7:0] ADDR_CTRL      = 8'h32;

  // field layout
  localparam int NTX_W        = 13;
  localparam int NBTX_W       = 3;
  localparam int NTX_LOW_LSB  = 3;
  localparam int NBTX_LSB     = 0;
  localparam int STATE_W      = 4;
  localparam int CTRL_ANCTL   = 0;
  localparam int CTRL_ISOA    = 1;
  localparam int EVT_PAR      = 0;
  localparam int EVT_TXE      = 1;

  // reset values
  localparam logic [7:0] CNT_HIGH_RST = 8'h00;
  localparam logic [7:0] CNT_LOW_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST     = 8'h02;
  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam logic [7:0] STS_RST      = 8'h00;
  localparam logic [7:0] RD_NONE      = 8'h00;

  // short frame contents: seven bits, no parity
  localparam logic [7:0]        REQA_CODE  = 8'h26;
  localparam logic [7:0]        WUPA_CODE  = 8'h52;
  localparam logic [NBTX_W-1:0] SHORT_BITS = 3'h7;

  // passive target state codes
  localparam logic [3:0] PTS_POWER_OFF = 4'h0;
  localparam logic [3:0] PTS_IDLE      = 4'h1;
  localparam logic [3:0] PTS_READY_L1  = 4'h2;
  localparam logic [3:0] PTS_READY_L2  = 4'h3;
  localparam logic [3:0] PTS_RSVD_A    = 4'h4;
  localparam logic [3:0] PTS_ACTIVE    = 4'h5;
  localparam logic [3:0] PTS_READY_L2S = 4'hb;
  localparam logic [3:0] PTS_RSVD_B    = 4'hc;
  localparam logic [3:0] PTS_ACTIVE_S  = 4'hd;

  typedef enum logic [1:0] {
    CMD_TX_CRC   = 2'h0,
    CMD_TX_NOCRC = 2'h1,
    CMD_REQA     = 2'h2,
    CMD_WUPA     = 2'h3
  } tfl_cmd_t;

  // serializer states, gray along idle-data-parity-done
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_DATA = 2'b01,
    SER_PAR  = 2'b11,
    SER_DONE = 2'b10
  } tfl_ser_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } tfl_bus_req_t;

  typedef struct packed {
    logic [NTX_W-1:0]  bytes;
    logic [NBTX_W-1:0] bits;
    logic              parity;
  } tfl_frame_cfg_t;

  // display value: reserved upper nibble forced to zero
  function automatic logic [7:0] tfl_state_byte(input logic [3:0] code);
    return {4'h0, code};
  endfunction

endpackage

//--- src/tfl_bit_ser.sv
// bit serializer: full bytes with optional odd parity, then a partial trailing byte
`timescale 1ns/10ps
module tfl_bit_ser (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  input  wire logic            start_i,
  input  tfl_pkg::tfl_frame_cfg_t cfg_i,
  input  wire logic [7:0]      byte_i,
  input  wire logic            tick_i,
  output logic                 take_o,
  output logic                 bit_o,
  output logic                 bit_valid_o,
  output logic                 done_o,
  output logic                 idle_o
);
  import tfl_pkg::*;

  tfl_ser_state_t     st_q;
  logic [NTX_W-1:0]   left_q;
  logic [NTX_W-1:0]   nxt_left;
  logic [NBTX_W-1:0]  bits_q;
  logic [2:0]         idx_q;
  logic [2:0]         top;
  logic               par_en_q;
  logic               last_q;
  logic               par_q;
  logic               nxt_end;
  logic [7:0]         sh_q;

  // last index of the current byte; partial byte stops after bits_q bits
  assign top      = last_q ? 3'(bits_q - 3'h1) : 3'h7;
  assign nxt_left = NTX_W'(left_q - 1'b1);
  assign nxt_end  = (nxt_left == '0) && (bits_q == '0);

  // frame walk; trailing-bit count and parity enable stay frozen from start to done, the byte count steps down
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q        <= SER_IDLE;
      left_q      <= '0;
      bits_q      <= '0;
      par_en_q    <= 1'b0;
      last_q      <= 1'b0;
      par_q       <= 1'b0;
      idx_q       <= 3'h0;
      sh_q        <= 8'h00;
      take_o      <= 1'b0;
      bit_o       <= 1'b0;
      bit_valid_o <= 1'b0;
      done_o      <= 1'b0;
      idle_o      <= 1'b1;
    end else if (ce_i) begin
      take_o      <= 1'b0;
      bit_valid_o <= 1'b0;
      done_o      <= 1'b0;
      case (st_q)
        SER_IDLE: begin
          if (start_i) begin
            left_q   <= cfg_i.bytes;
            bits_q   <= cfg_i.bits;
            par_en_q <= cfg_i.parity;
            idle_o   <= 1'b0;
            if (cfg_i.bytes == '0 && cfg_i.bits == '0) begin
              st_q <= SER_DONE;
            end else begin
              sh_q   <= byte_i;
              take_o <= 1'b1;
              idx_q  <= 3'h0;
              par_q  <= 1'b0;
              last_q <= (cfg_i.bytes == '0);
              st_q   <= SER_DATA;
            end
          end
        end
        SER_DATA: begin
          if (tick_i) begin
            bit_o       <= sh_q[0];
            bit_valid_o <= 1'b1;
            sh_q        <= {1'b0, sh_q[7:1]};
            par_q       <= par_q ^ sh_q[0];
            idx_q       <= 3'(idx_q + 3'h1);
            if (idx_q == top) begin
              if (last_q) begin
                st_q <= SER_DONE;
              end else if (par_en_q) begin
                st_q <= SER_PAR;
              end else if (nxt_end) begin
                st_q <= SER_DONE;
              end else begin
                left_q <= nxt_left;
                sh_q   <= byte_i;
                take_o <= 1'b1;
                idx_q  <= 3'h0;
                par_q  <= 1'b0;
                last_q <= (nxt_left == '0);
              end
            end
          end
        end
        SER_PAR: begin
          if (tick_i) begin
            bit_o       <= ~par_q; // odd parity over the byte
            bit_valid_o <= 1'b1;
            if (nxt_end) begin
              st_q <= SER_DONE;
            end else begin
              left_q <= nxt_left;
              sh_q   <= byte_i;
              take_o <= 1'b1;
              idx_q  <= 3'h0;
              par_q  <= 1'b0;
              last_q <= (nxt_left == '0);
              st_q   <= SER_DATA;
            end
          end
        end
        default: begin
          done_o <= 1'b1;
          idle_o <= 1'b1;
          st_q   <= SER_IDLE;
        end
      endcase
    end
  end

  // parity state is only reachable when parity was enabled at start
  property p_no_par_state;
    @(posedge ref_clk_i) disable iff (rst_i)
      (st_q == SER_PAR) |-> par_en_q;
  endproperty
  a_no_par_state: assert property (p_no_par_state) else $error("parity state without parity");

  // trailing-bit count and parity enable hold while a frame is running
  property p_cfg_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      (st_q != SER_IDLE && st_q != SER_DONE) |=> $stable(bits_q) && $stable(par_en_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("frame counts changed mid frame");

  // the first bit of a loaded byte is its least significant bit
  property p_lsb_first;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ce_i && st_q == SER_DATA && tick_i && idx_q == 3'h0) |=> (bit_valid_o && bit_o == $past(sh_q[0]));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first bit is not the lsb");

endmodule

//--- src/tfl_regs.sv
// register bank for target state display and tx frame length, with command start and interrupt
`timescale 1ns/10ps
module tfl_regs (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  tfl_pkg::tfl_bus_req_t      bus_i,
  output logic [7:0]                 rd_data_o,
  input  wire logic [3:0]            pta_state_i,
  input  wire logic                  cmd_valid_i,
  input  tfl_pkg::tfl_cmd_t          cmd_i,
  input  wire logic [7:0]            tx_byte_i,
  input  wire logic                  bit_tick_i,
  output logic                       tx_byte_take_o,
  output logic                       tx_bit_o,
  output logic                       tx_bit_valid_o,
  output logic                       tx_crc_en_o,
  output logic                       tx_busy_o,
  output logic                       tx_done_o,
  output logic                       irq_o
);
  import tfl_pkg::*;

  logic [7:0]        cnt_high_q;
  logic [7:0]        cnt_low_q;
  logic [7:0]        ctrl_q;
  logic [7:0]        mask_q;
  logic [7:0]        mask_d;
  logic [7:0]        sts_q;
  logic [7:0]        sts_d;
  logic [7:0]        evt;
  logic [7:0]        w1c;
  logic              cmd_go;
  logic              is_short;
  logic              par_evt;
  logic              isoa;
  logic              short_q;
  logic [7:0]        short_code_q;
  logic [7:0]        ser_byte;
  logic              ser_done;
  logic              ser_idle;
  logic              start_q;
  logic [NTX_W-1:0]  ntx;
  logic [NBTX_W-1:0] nbtx;
  tfl_frame_cfg_t    cfg_d;
  tfl_frame_cfg_t    cfg_q;

  // length fields as the framer sees them
  assign ntx  = {cnt_high_q, cnt_low_q[7:NTX_LOW_LSB]};
  assign nbtx = cnt_low_q[NBTX_LSB +: NBTX_W];
  assign isoa = ctrl_q[CTRL_ISOA];

  // a command is taken only while no frame is in flight; others are dropped
  assign cmd_go   = ce_i && cmd_valid_i && !tx_busy_o && !start_q;
  assign is_short = (cmd_i == CMD_REQA) || (cmd_i == CMD_WUPA);

  // wrong trailing-bit setup for an idle card during anticollision
  assign par_evt = cmd_go && is_short && ctrl_q[CTRL_ANCTL]
                   && (pta_state_i == PTS_IDLE) && (nbtx != '0);

  // frame setup; trailing bits only honoured for ISO-A without CRC
  always_comb begin
    cfg_d = '0;
    if (is_short) begin
      cfg_d.bytes  = '0;
      cfg_d.bits   = SHORT_BITS;
      cfg_d.parity = 1'b0;
    end else if (cmd_i == CMD_TX_NOCRC && isoa) begin
      cfg_d.bytes  = ntx;
      cfg_d.bits   = nbtx;
      cfg_d.parity = (nbtx == '0);
    end else begin
      cfg_d.bytes  = ntx;
      cfg_d.bits   = '0;
      cfg_d.parity = isoa;
    end
  end

  // latch the frame at command time; the registers may change afterwards
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cfg_q        <= '0;
      start_q      <= 1'b0;
      short_q      <= 1'b0;
      short_code_q <= 8'h00;
      tx_crc_en_o  <= 1'b0;
    end else if (ce_i) begin
      start_q <= cmd_go;
      if (cmd_go) begin
        cfg_q        <= cfg_d;
        short_q      <= is_short;
        short_code_q <= (cmd_i == CMD_WUPA) ? WUPA_CODE : REQA_CODE;
        tx_crc_en_o  <= (cmd_i == CMD_TX_CRC);
      end
    end
  end

  // busy from the taken command until the serializer reports done
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_busy_o <= 1'b0;
      tx_done_o <= 1'b0;
    end else if (ce_i) begin
      tx_done_o <= ser_done;
      if (cmd_go) begin
        tx_busy_o <= 1'b1;
      end else if (ser_done) begin
        tx_busy_o <= 1'b0;
      end
    end
  end

  // short frames carry a fixed code instead of a host byte
  assign ser_byte = short_q ? short_code_q : tx_byte_i;

  tfl_bit_ser u_ser (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .start_i     (start_q),
    .cfg_i       (cfg_q),
    .byte_i      (ser_byte),
    .tick_i      (bit_tick_i),
    .take_o      (tx_byte_take_o),
    .bit_o       (tx_bit_o),
    .bit_valid_o (tx_bit_valid_o),
    .done_o      (ser_done),
    .idle_o      (ser_idle)
  );

  // length, mask and control registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_high_q <= CNT_HIGH_RST;
      cnt_low_q  <= CNT_LOW_RST;
      ctrl_q     <= CTRL_RST;
      mask_q     <= MASK_RST;
    end else if (ce_i && bus_i.we) begin
      if (bus_i.addr == ADDR_CNT_HIGH) begin
        cnt_high_q <= bus_i.wdata;
      end else if (bus_i.addr == ADDR_CNT_LOW) begin
        cnt_low_q <= bus_i.wdata;
      end else if (bus_i.addr == ADDR_IRQ_MASK) begin
        mask_q <= bus_i.wdata;
      end else if (bus_i.addr == ADDR_CTRL) begin
        ctrl_q <= bus_i.wdata & 8'h03;
      end
    end
  end

  // sticky events: a set in the clearing cycle survives the clear
  always_comb begin
    evt          = 8'h00;
    evt[EVT_PAR] = par_evt;
    evt[EVT_TXE] = ser_done;
    w1c          = (bus_i.we && bus_i.addr == ADDR_IRQ_STS) ? bus_i.wdata : 8'h00;
    sts_d        = (sts_q & ~w1c) | evt;
    mask_d       = (bus_i.we && bus_i.addr == ADDR_IRQ_MASK) ? bus_i.wdata : mask_q;
  end

  // status and line; a mask write counts at once, so irq never lags the registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sts_q <= STS_RST;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      sts_q <= sts_d;
      irq_o <= |(sts_d & mask_d);
    end
  end

  // read port: data stands in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_data_o <= RD_NONE;
    end else if (ce_i && bus_i.re) begin
      if (bus_i.addr == ADDR_TGT_STATE) begin
        rd_data_o <= tfl_state_byte(pta_state_i);
      end else if (bus_i.addr == ADDR_CNT_HIGH) begin
        rd_data_o <= cnt_high_q;
      end else if (bus_i.addr == ADDR_CNT_LOW) begin
        rd_data_o <= cnt_low_q;
      end else if (bus_i.addr == ADDR_IRQ_STS) begin
        rd_data_o <= sts_q;
      end else if (bus_i.addr == ADDR_IRQ_MASK) begin
        rd_data_o <= mask_q;
      end else if (bus_i.addr == ADDR_CTRL) begin
        rd_data_o <= ctrl_q;
      end else begin
        rd_data_o <= RD_NONE;
      end
    end
  end

  // state display carries the live code with a zero upper nibble
  property p_state_read;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ce_i && bus_i.re && bus_i.addr == ADDR_TGT_STATE)
        |=> (rd_data_o[3:0] == $past(pta_state_i));
  endproperty
  a_state_read: assert property (p_state_read) else $error("state code readback wrong");

  property p_state_rsvd;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ce_i && bus_i.re && bus_i.addr == ADDR_TGT_STATE) |=> (rd_data_o[7:4] == 4'h0);
  endproperty
  a_state_rsvd: assert property (p_state_rsvd) else $error("state upper nibble not zero");

  // written high count shows up in the upper bits of the 13-bit length
  property p_ntx_high;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ce_i && bus_i.we && bus_i.addr == ADDR_CNT_HIGH)
        |=> (ntx[NTX_W-1:5] == $past(bus_i.wdata));
  endproperty
  a_ntx_high: assert property (p_ntx_high) else $error("byte count high bits wrong");

  property p_nbtx_low;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ce_i && bus_i.we && bus_i.addr == ADDR_CNT_LOW)
        |=> (nbtx == $past(bus_i.wdata[2:0]) && ntx[4:0] == $past(bus_i.wdata[7:3]));
  endproperty
  a_nbtx_low: assert property (p_nbtx_low) else $error("low length fields wrong");

  // the illegal short-frame setup raises the parity event on the next edge
  property p_par_irq;
    @(posedge ref_clk_i) disable iff (rst_i)
      par_evt |=> sts_q[EVT_PAR];
  endproperty
  a_par_irq: assert property (p_par_irq) else $error("parity event not raised");

  // frame counts are captured from the registers when the command is taken
  property p_capture;
    @(posedge ref_clk_i) disable iff (rst_i)
      (cmd_go && cmd_i == CMD_TX_NOCRC && isoa)
        |=> (cfg_q.bytes == $past(ntx) && cfg_q.bits == $past(nbtx) && start_q);
  endproperty
  a_capture: assert property (p_capture) else $error("frame counts not captured");

  // a partial trailer never comes with parity enabled
  property p_trailer_nopar;
    @(posedge ref_clk_i) disable iff (rst_i)
      (start_q && cfg_q.bits != '0) |-> !cfg_q.parity;
  endproperty
  a_trailer_nopar: assert property (p_trailer_nopar) else $error("parity with partial byte");

  // no bit leaves the serializer while it is idle and no frame is busy
  property p_quiet_idle;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!tx_busy_o && !start_q && ser_idle) |=> !tx_bit_valid_o;
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("bit sent outside a frame");

  // a one written to a status bit clears it when no event arrives alongside
  property p_w1c;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ce_i && bus_i.we && bus_i.addr == ADDR_IRQ_STS && evt == 8'h00)
        |=> ((sts_q & $past(bus_i.wdata)) == 8'h00);
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");

  // the line follows status and mask with no extra cycle of lag
  property p_irq_level;
    @(posedge ref_clk_i) disable iff (rst_i)
      ce_i
        |=> (irq_o == (|(sts_q & mask_q)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq line disagrees with status");

  // the parity status bit only rises after the illegal short-frame setup
  property p_par_cause;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!sts_q[EVT_PAR] ##1 sts_q[EVT_PAR])
        |-> $past(par_evt);
  endproperty
  a_par_cause: assert property (p_par_cause) else $error("parity status without cause");

  // a command during a frame is dropped and leaves the latched counts alone
  property p_busy_drop;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ce_i && cmd_valid_i && tx_busy_o)
        |=> (!start_q && $stable(cfg_q));
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("command taken while busy");

  // trailing bits only count for iso-a without crc; other non-short frames send whole bytes
  property p_bits_forced;
    @(posedge ref_clk_i) disable iff (rst_i)
      (cmd_go && !is_short && !(cmd_i == CMD_TX_NOCRC && isoa))
        |=> (cfg_q.bits == '0 && cfg_q.parity == $past(isoa));
  endproperty
  a_bits_forced: assert property (p_bits_forced) else $error("trailing bits not dropped");

  // short frames are seven bits with no parity and no full byte
  property p_short_cfg;
    @(posedge ref_clk_i) disable iff (rst_i)
      (cmd_go && is_short)
        |=> (cfg_q.bytes == '0 && cfg_q.bits == SHORT_BITS && !cfg_q.parity);
  endproperty
  a_short_cfg: assert property (p_short_cfg) else $error("short frame setup wrong");

  // the done pulse comes with the port free again for the next command
  property p_done_free;
    @(posedge ref_clk_i) disable iff (rst_i)
      tx_done_o
        |-> (!tx_busy_o && ser_idle);
  endproperty
  a_done_free: assert property (p_done_free) else $error("busy still set at done");

endmodule

//--- bench/tfl_src_model.sv
// framer-side partner: byte source advanced by consumption, and bit-rate ticks
`timescale 1ns/10ps
module tfl_src_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       take_i,
  output logic [7:0]      tx_byte_o,
  output logic            tick_o
);
  logic [7:0] idx_q;
  logic       ph_q;

  // ticks at half the clock rate, so the serializer really has to wait for them
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
    end
  end

  // one byte per consumption; no handshake back, the source just moves on
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      idx_q <= 8'h00;
    end else if (take_i) begin
      idx_q <= idx_q + 8'h01;
    end
  end

  assign tick_o    = ph_q;
  // every byte differs from its neighbours, so a skipped or repeated byte shows
  assign tx_byte_o = {idx_q[3:0], ~idx_q[3:0]};
endmodule

//--- bench/tx_frame_length_and_target_state_tb_top.sv
// self-checking testbench for the tx frame length and target state bank
`timescale 1ns/10ps
module tx_frame_length_and_target_state_tb_top;
  import tfl_pkg::*;
  logic         ref_clk_i = 1'b0;
  logic         rst_i     = 1'b1;
  logic         ce_i      = 1'b1;
  tfl_bus_req_t bus       = '0;
  logic [3:0]   pta       = 4'h0;
  logic         cmd_vld   = 1'b0;
  tfl_cmd_t     cmd       = CMD_TX_CRC;
  logic [7:0]   rd_data;
  logic [7:0]   tx_byte;
  logic         tick, take, tx_bit, bit_vld, crc_en, busy, done, irq;
  int           n_fail       = 0;
  int           total_checks = 0;
  int           take_exp     = 0;
  logic         exp_q[$];
  logic         got_q[$];

  tfl_regs u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus),
    .rd_data_o(rd_data), .pta_state_i(pta), .cmd_valid_i(cmd_vld), .cmd_i(cmd),
    .tx_byte_i(tx_byte), .bit_tick_i(tick), .tx_byte_take_o(take),
    .tx_bit_o(tx_bit), .tx_bit_valid_o(bit_vld), .tx_crc_en_o(crc_en),
    .tx_busy_o(busy), .tx_done_o(done), .irq_o(irq)
  );

  tfl_src_model u_src (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .take_i(take),
    .tx_byte_o(tx_byte), .tick_o(tick)
  );

  // 10 MHz clock
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bus tasks are entered just after a rising edge and leave just after one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.we    <= 1'b1;
    @(posedge ref_clk_i);
    bus.we    <= 1'b0;
    // idle edge, so a following write never sets we in the step that lowered it
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus.addr <= a;
    bus.re   <= 1'b1;
    @(posedge ref_clk_i);
    bus.re   <= 1'b0;
    @(negedge ref_clk_i);
    chk($sformatf("reg %h", a), exp, rd_data);
    @(posedge ref_clk_i);
  endtask

  // mirror of the source pattern, worked out here rather than read back
  function automatic logic [7:0] sb(input logic [7:0] k);
    return {k[3:0], ~k[3:0]};
  endfunction

  task automatic push_byte(input logic [7:0] b, input int n, input logic par);
    for (int i = 0; i < n; i++) exp_q.push_back(b[i]);
    if (par) exp_q.push_back(~^b);
    take_exp++;
  endtask

  // issue one command and compare the serial bits against exp_q
  task automatic send(input tfl_cmd_t c);
    int takes = 0;
    cmd     <= c;
    cmd_vld <= 1'b1;
    @(posedge ref_clk_i);
    cmd_vld <= 1'b0;
    got_q = {};
    for (int i = 0; i < 1000; i++) begin
      @(negedge ref_clk_i);
      if (i == 0) chk("busy", 1, busy);
      if (bit_vld === 1'b1) got_q.push_back(tx_bit);
      if (take === 1'b1) takes++;
      if (done === 1'b1) break;
    end
    chk("done", 1, done);
    chk("bit count", exp_q.size(), got_q.size());
    chk("byte takes", take_exp, takes);
    foreach (exp_q[i]) chk($sformatf("bit %0d", i), exp_q[i], got_q[i]);
    @(negedge ref_clk_i);
    chk("busy after done", 0, busy);
    @(posedge ref_clk_i);
    exp_q = {};
    take_exp = 0;
  endtask

  task automatic t_reset;
    rd(ADDR_CNT_HIGH, CNT_HIGH_RST);
    rd(ADDR_CNT_LOW, CNT_LOW_RST);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_IRQ_MASK, MASK_RST);
    rd(ADDR_IRQ_STS, STS_RST);
    rd(8'h40, RD_NONE);
  endtask

  task automatic t_state;
    logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb, 4'hc, 4'hd};
    wr(ADDR_TGT_STATE, 8'hff);
    foreach (codes[i]) begin
      pta <= codes[i];
      rd(ADDR_TGT_STATE, {4'h0, codes[i]});
    end
  endtask

  // no-crc frame of two bytes and three trailing bits; lengths rewritten mid-frame
  task automatic t_nocrc;
    logic [7:0] k;
    wr(ADDR_CNT_HIGH, 8'hff);
    wr(ADDR_CNT_LOW, 8'hff);
    rd(ADDR_CNT_HIGH, 8'hff);
    rd(ADDR_CNT_LOW, 8'hff);
    wr(ADDR_CNT_HIGH, 8'h00);
    wr(ADDR_CNT_LOW, 8'h13);
    k = u_src.idx_q;
    push_byte(sb(k), 8, 1'b0);
    push_byte(sb(k + 8'h01), 8, 1'b0);
    push_byte(sb(k + 8'h02), 3, 1'b0);
    // the frame with trailing bits goes out with the no-crc command
    fork
      send(CMD_TX_NOCRC);
      begin
        repeat (6) @(posedge ref_clk_i);
        wr(ADDR_CNT_LOW, 8'h08);
        // a command while the frame is in flight must be dropped
        cmd     <= CMD_REQA;
        cmd_vld <= 1'b1;
        @(posedge ref_clk_i);
        cmd_vld <= 1'b0;
      end
    join
    chk("crc enable", 0, crc_en);
  endtask

  // with crc the trailing bits are ignored and every byte carries odd parity
  task automatic t_crc;
    logic [7:0] k;
    wr(ADDR_CNT_HIGH, 8'h01);
    wr(ADDR_CNT_LOW, 8'h0b);
    k = u_src.idx_q;
    for (int i = 0; i < 33; i++) push_byte(sb(k + 8'(i)), 8, 1'b1);
    send(CMD_TX_CRC);
    chk("crc enable", 1, crc_en);
    // iso-a without crc and no trailing bits keeps parity on the byte
    wr(ADDR_CNT_HIGH, 8'h00);
    wr(ADDR_CNT_LOW, 8'h08);
    k = u_src.idx_q;
    push_byte(sb(k), 8, 1'b1);
    send(CMD_TX_NOCRC);
    // outside iso-a the trailing bits are dropped and no parity is sent
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CNT_LOW, 8'h0b);
    k = u_src.idx_q;
    push_byte(sb(k), 8, 1'b0);
    send(CMD_TX_NOCRC);
    wr(ADDR_CTRL, 8'h02);
  endtask

  // with the clock enable low a write must leave the register untouched
  task automatic t_ce;
    ce_i <= 1'b0;
    wr(ADDR_CNT_HIGH, 8'h5a);
    ce_i <= 1'b1;
    rd(ADDR_CNT_HIGH, 8'h00);
  endtask

  task automatic t_irq;
    wr(ADDR_CNT_HIGH, 8'h00);
    wr(ADDR_CNT_LOW, 8'h03);
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_IRQ_STS, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h01);
    pta <= PTS_IDLE;
    push_byte(REQA_CODE, 7, 1'b0);
    send(CMD_REQA);
    chk("irq set", 1, irq);
    rd(ADDR_IRQ_STS, 8'h03);
    wr(ADDR_IRQ_STS, 8'h03);
    @(negedge ref_clk_i);
    chk("irq cleared", 0, irq);
    @(posedge ref_clk_i);
    // masked: the status bit still sets, the line stays low
    wr(ADDR_IRQ_MASK, 8'h00);
    push_byte(WUPA_CODE, 7, 1'b0);
    send(CMD_WUPA);
    chk("irq masked", 0, irq);
    wr(ADDR_IRQ_MASK, 8'h01);
    @(negedge ref_clk_i);
    chk("irq unmasked", 1, irq);
    @(posedge ref_clk_i);
    wr(ADDR_IRQ_STS, 8'h03);
    // an active target is the host's business, no parity event
    pta <= PTS_ACTIVE;
    push_byte(REQA_CODE, 7, 1'b0);
    send(CMD_REQA);
    rd(ADDR_IRQ_STS, 8'h02);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    t_reset();
    t_state();
    t_nocrc();
    t_crc();
    t_irq();
    t_ce();
    tally_and_finish();
  end

  // watchdog well beyond the under one thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    tally_and_finish();
  end
endmodule
